/* File: hdl/sh_select_pkg.sv */
package sh_select_pkg;

	// wishbone map
	localparam logic [3:0]  OFFS_SH_CHANNEL_INPUT_SELECT = 4'h0;
	localparam logic [3:0]  OFFS_SAMPLE_CONTROL          = 4'h4;
	localparam logic [31:0] UNMAPPED_READ                = 32'h0000_0000;

	// field positions in sh_channel_input_select
	localparam int SAMP_B_NEG_HI = 10;
	localparam int SAMP_B_NEG_LO = 9;
	localparam int SAMP_B_POS    = 8;
	localparam int SAMP_A_NEG_HI = 2;
	localparam int SAMP_A_NEG_LO = 1;
	localparam int SAMP_A_POS    = 0;
	localparam logic [15:0] SEL_IMPL_MASK  = 16'h0707;
	localparam logic [15:0] SEL_RESET      = 16'h0000;

	// sample control register: bit 0 selects sample b
	localparam int CTRL_SAMPLE_B = 0;
	localparam logic [15:0] CTRL_IMPL_MASK = 16'h0001;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;

	// multiplexer codes
	localparam logic [2:0] POS_NONE = 3'h0;
	localparam logic [2:0] POS_AN0  = 3'h1;
	localparam logic [2:0] POS_AN1  = 3'h2;
	localparam logic [2:0] POS_AN2  = 3'h3;
	localparam logic [2:0] POS_AN3  = 3'h4;
	localparam logic [2:0] POS_AN4  = 3'h5;
	localparam logic [2:0] POS_AN5  = 3'h6;

	typedef enum logic [1:0] {
		NEG_GROUND   = 2'b00,
		NEG_RESERVED = 2'b01
	} neg_route_e;

	typedef struct packed {
		logic [2:0] pos_sh1;
		logic [2:0] pos_sh2;
		logic [2:0] pos_sh3;
		neg_route_e neg;
	} mux_route_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
		logic [15:0] sel;
		logic        sample_b;
		mux_route_s  route;
	} block_state_s;

endpackage : sh_select_pkg

/* File: hdl/sh_route_decode.sv */
`timescale 1ns/1ps
module sh_route_decode
	import sh_select_pkg::*;
(
	// field values of the active sample and the variant strap
	input  wire logic       pos_sel_i,
	input  wire logic [1:0] neg_sel_i,
	input  wire logic       large_variant_i,
	// decoded route
	output mux_route_s      route_o
);

	always_comb begin
		route_o.neg = neg_sel_i[1] ? NEG_RESERVED : NEG_GROUND;
		if (!pos_sel_i) begin
			route_o.pos_sh1 = POS_AN0;
			route_o.pos_sh2 = POS_AN1;
			route_o.pos_sh3 = POS_AN2;
		end else if (large_variant_i) begin
			route_o.pos_sh1 = POS_AN3;
			route_o.pos_sh2 = POS_AN4;
			route_o.pos_sh3 = POS_AN5;
		end else begin
			route_o.pos_sh1 = POS_AN3;
			route_o.pos_sh2 = POS_NONE;
			route_o.pos_sh3 = POS_NONE;
		end
	end

endmodule : sh_route_decode

/* File: hdl/sh_channel_select.sv */
// Notes on behaviour
// - positive select 0 routes inputs 0,1,2 to holds 1,2,3.
// - small variant, select 1: input 3 to hold 1, others open.
// - large variant, select 1: inputs 3,4,5 to holds 1,2,3.
// - sample B positive select is bit 8, used during sample B.
// - bits 7-3 ignore writes and read zero.
// - sample A negative field bits 2-1, same encoding as sample B.
// - sample A positive select is bit 0, same routing.
// - bits 15-11 read zero.
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module sh_channel_select
	import sh_select_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// variant strap, 1 = larger pin count
	input  wire logic        large_variant_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// analog multiplexer control
	output logic      [2:0]  pos_sh1_o,
	output logic      [2:0]  pos_sh2_o,
	output logic      [2:0]  pos_sh3_o,
	output logic      [1:0]  neg_route_o,
	output logic             sample_b_o
);

	block_state_s state;
	block_state_s next_state;
	mux_route_s   route_active;
	logic         act_pos;
	logic [1:0]   act_neg;
	logic [15:0]  wr_val;
	logic         req;

	// field pick for the active sample
	always_comb begin
		if (state.sample_b) begin
			act_pos = state.sel[SAMP_B_POS];
			act_neg = state.sel[SAMP_B_NEG_HI:SAMP_B_NEG_LO];
		end else begin
			act_pos = state.sel[SAMP_A_POS];
			act_neg = state.sel[SAMP_A_NEG_HI:SAMP_A_NEG_LO];
		end
	end

	sh_route_decode u_decode (
		.pos_sel_i       (act_pos),
		.neg_sel_i       (act_neg),
		.large_variant_i (large_variant_i),
		.route_o         (route_active)
	);

	assign req = cyc_i & stb_i & ~state.ack;

	// byte lane merge over the low 16 bits
	always_comb begin
		wr_val = state.sel;
		if (sel_i[0]) begin
			wr_val[7:0] = dat_i[7:0];
		end
		if (sel_i[1]) begin
			wr_val[15:8] = dat_i[15:8];
		end
	end

	always_comb begin
		next_state       = state;
		next_state.ack   = req;
		next_state.route = route_active;
		if (req) begin
			case (adr_i)
				OFFS_SH_CHANNEL_INPUT_SELECT: begin
					if (we_i) begin
						next_state.sel = wr_val & SEL_IMPL_MASK;
					end
					next_state.dat = {16'h0000, state.sel & SEL_IMPL_MASK};
				end
				OFFS_SAMPLE_CONTROL: begin
					if (we_i && sel_i[0]) begin
						next_state.sample_b = dat_i[CTRL_SAMPLE_B];
					end
					next_state.dat = {16'h0000, {15'h0000, state.sample_b} & CTRL_IMPL_MASK};
				end
				default: begin
					next_state.dat = UNMAPPED_READ;
				end
			endcase
		end
		if (rst_i) begin
			next_state.ack      = 1'b0;
			next_state.dat      = 32'h0000_0000;
			next_state.sel      = SEL_RESET;
			next_state.sample_b = CTRL_RESET[CTRL_SAMPLE_B];
			next_state.route    = '{POS_AN0, POS_AN1, POS_AN2, NEG_GROUND};
		end
	end

	always_ff @(posedge clk_i) begin
		state <= next_state;
	end

	assign ack_o       = state.ack;
	assign dat_o       = state.dat;
	assign pos_sh1_o   = state.route.pos_sh1;
	assign pos_sh2_o   = state.route.pos_sh2;
	assign pos_sh3_o   = state.route.pos_sh3;
	assign neg_route_o = state.route.neg;
	assign sample_b_o  = state.sample_b;

endmodule : sh_channel_select

/* File: verif/sh_select_props.sv */
`timescale 1ns/1ps
module sh_select_props
	import sh_select_pkg::*;
(
	// clock and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        large_variant_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic [31:0] dat_o,
	// route
	input wire logic [2:0]  pos_sh1_o,
	input wire logic [2:0]  pos_sh2_o,
	input wire logic [2:0]  pos_sh3_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take; cyc_i && stb_i && !ack_o; endsequence
	sequence s_in3; pos_sh1_o == POS_AN3; endsequence
	property p_ack; s_take |=> ack_o; endproperty
	property p_pulse; ack_o |=> !ack_o; endproperty
	property p_hi; ack_o |-> dat_o[15:11] == 5'h0; endproperty
	property p_mid; ack_o |-> dat_o[7:3] == 5'h0; endproperty
	property p_zero; pos_sh1_o == POS_AN0 |-> {pos_sh2_o, pos_sh3_o} == {POS_AN1, POS_AN2};
	endproperty
	property p_small; !$past(large_variant_i) ##0 s_in3 |-> pos_sh2_o == POS_NONE;
	endproperty
	property p_large; $past(large_variant_i) ##0 s_in3 |-> pos_sh3_o == POS_AN5;
	endproperty
	property p_rst; disable iff (1'b0) rst_i |=> !ack_o && pos_sh1_o == POS_AN0;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	a_pulse: assert property (p_pulse) else $error("ack too long");
	a_hi: assert property (p_hi) else $error("high bits set");
	a_mid: assert property (p_mid) else $error("middle bits set");
	a_zero: assert property (p_zero) else $error("bad route 0");
	a_small: assert property (p_small) else $error("bad small route");
	a_large: assert property (p_large) else $error("bad large route");
	a_rst: assert property (p_rst) else $error("bad reset");
endmodule : sh_select_props
bind sh_channel_select sh_select_props u_props (.clk_i(clk_i), .rst_i(rst_i),
	.large_variant_i(large_variant_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.dat_o(dat_o), .pos_sh1_o(pos_sh1_o), .pos_sh2_o(pos_sh2_o), .pos_sh3_o(pos_sh3_o));

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import sh_select_pkg::*;
	logic        clk_i, rst_i, large_variant_i, cyc_i, stb_i, we_i, ack_o, sample_b_o;
	logic [3:0]  adr_i, sel_i;
	logic [31:0] dat_i, dat_o, r, v, m;
	logic [2:0]  pos_sh1_o, pos_sh2_o, pos_sh3_o;
	logic [1:0]  neg_route_o;
	int          n_errors, total_checks, seed, i;
	sh_channel_select uut (.clk_i(clk_i), .rst_i(rst_i), .large_variant_i(large_variant_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pos_sh1_o(pos_sh1_o),
		.pos_sh2_o(pos_sh2_o), .pos_sh3_o(pos_sh3_o), .neg_route_o(neg_route_o),
		.sample_b_o(sample_b_o));
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		r = dat_o;
		{cyc_i, stb_i} <= 2'b00;
	endtask : wb
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	function automatic logic [10:0] rt(input logic p, input logic [1:0] n, input logic l);
		return {p ? (l ? 9'h12e : 9'h100) : 9'h053, 1'b0, n[1]};
	endfunction : rt
	task automatic end_of_test;
		if (n_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	initial begin
		clk_i = 0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		n_errors++;
		end_of_test;
	end
	initial begin
		{rst_i, large_variant_i, cyc_i, stb_i, we_i, adr_i, dat_i} = {1'b1, 40'h00_0000_0000};
		sel_i = 4'hf;
		seed = 8;
		m = 0;
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		wb(0, OFFS_SH_CHANNEL_INPUT_SELECT, 0);
		chk(r, SEL_RESET);
		wb(0, 4'h8, 0);
		chk(r, UNMAPPED_READ);
		for (i = 0; i < 40; i++) begin
			v = $random(seed);
			sel_i <= {2'b11, v[27:26]};
			wb(1, OFFS_SH_CHANNEL_INPUT_SELECT, v);
			chk(r, m);
			m = {16'h0000, v[27] ? v[15:8] : m[15:8], v[26] ? v[7:0] : m[7:0]} & 32'h0000_0707;
			sel_i <= 4'hf;
			wb(1, OFFS_SAMPLE_CONTROL, v[31:16]);
			large_variant_i <= v[20];
			wb(0, OFFS_SH_CHANNEL_INPUT_SELECT, 0);
			chk(r, m);
			chk({pos_sh1_o, pos_sh2_o, pos_sh3_o, neg_route_o, sample_b_o},
				{v[16] ? rt(m[8], m[10:9], v[20]) : rt(m[0], m[2:1], v[20]), v[16]});
		end
		// mid-run reset returns every register field to zero and routes inputs 0,1,2 to holds 1,2,3
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		wb(0, OFFS_SH_CHANNEL_INPUT_SELECT, 0);
		chk(r, SEL_RESET);
		chk({pos_sh1_o, pos_sh2_o, pos_sh3_o, neg_route_o, sample_b_o}, {9'h053, 3'h0});
		end_of_test;
	end
endmodule : tb_top
